// [common/mmb_pkg.sv]
// Purpose: constants and carriers for the memory map and bank decoder
// Assumes: one core clock, synchronous active-high reset
// Notes: program addresses in words, data addresses in bytes
package mmb_pkg;
  localparam int PC_W = 13;
  localparam int IMPL_W = 12;
  localparam int WORD_W = 14;
  localparam int DADDR_W = 7;
  localparam int FULL_W = 9;
  localparam int BANK_W = 2;
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
  localparam int BSEL_HI_POS = 6;
  localparam int BSEL_LO_POS = 5;
  localparam logic [BANK_W-1:0] BANK0 = 2'h0;
  localparam logic [BANK_W-1:0] BANK1 = 2'h1;
  localparam logic [DADDR_W-1:0] SFR_LAST = 7'h1F;
  localparam logic [DADDR_W-1:0] BANK_TOP = 7'h7F;
  localparam logic [DADDR_W-1:0] IND_ADDR = 7'h00;
  localparam logic [DADDR_W-1:0] PCLO_ADDR = 7'h02;
  localparam logic [DADDR_W-1:0] FLAG_ADDR = 7'h03;
  localparam logic [DADDR_W-1:0] PTR_ADDR = 7'h04;
  localparam logic [DADDR_W-1:0] PCHI_ADDR = 7'h0A;
  localparam logic [DADDR_W-1:0] INTC_ADDR = 7'h0B;

  typedef enum logic [2:0] {
    MMB_REG_NONE = 3'b001,
    MMB_REG_SFR = 3'b010,
    MMB_REG_GPR = 3'b100
  } mmb_region_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic indirect;
    logic [DADDR_W-1:0] addr;
    logic [7:0] wdata;
  } mmb_dreq_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [FULL_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    mmb_region_t region;
    logic mirrored;
    logic [7:0] wdata;
  } mmb_dsel_t;
endpackage

// [src/mmb_bank_decode.sv]
// Purpose: classify a full data address into bank, region and mirror
// Assumes: combinational, driven from the same clock domain
// Notes: banks above bank 1 decode to no region
`timescale 1ns/10ps
`default_nettype none
module mmb_bank_decode (
  // address
  input wire logic [mmb_pkg::FULL_W-1:0] full_addr_i,
  // classification
  output mmb_pkg::mmb_region_t region_o,
  output logic mirrored_o
);
  import mmb_pkg::*;
  logic [BANK_W-1:0] bank;
  logic [DADDR_W-1:0] off;

  always_comb begin
    bank = full_addr_i[FULL_W-1:DADDR_W];
    off = full_addr_i[DADDR_W-1:0];
    region_o = MMB_REG_NONE;
    if (bank == BANK0 || bank == BANK1) begin
      if (off <= SFR_LAST) begin
        region_o = MMB_REG_SFR;
      end else if (off <= BANK_TOP) begin
        region_o = MMB_REG_GPR;
      end
    end
    // shared core registers decode identically in both banks
    mirrored_o = (region_o == MMB_REG_SFR) && (off == IND_ADDR || off == PCLO_ADDR ||
      off == FLAG_ADDR || off == PTR_ADDR || off == PCHI_ADDR || off == INTC_ADDR);
  end
endmodule
`default_nettype wire

// [src/mmb_memory_map.sv]
// Purpose: program counter and data address organisation of a small core
// Assumes: core asserts fetch and data requests each cycle on ref_clk_i
// Notes: fetch and data paths are separate registered outputs
// Functional notes
// - fetch and data access have separate buses, usable in one cycle.
// - program counter is 13 bits, space 8K words of 14 bits.
// - only 4K words exist; higher fetch addresses wrap onto them.
// - reset loads program counter with 0000h; first fetch after release is at 0001h.
// - taking an interrupt redirects fetch to 0004h.
// - flag bits 6:5 select bank for direct access; 00 bank0, 01 bank1, others unimplemented.
// - each of banks 0 and 1 decodes offsets up to 7Fh, 128 bytes.
// - special registers sit low in a bank, static RAM above.
// - banks 0 and 1 each have special registers; some mirror across them.
// - data reached directly or through the indirect pointer register.
`timescale 1ns/10ps
`default_nettype none
module mmb_memory_map #(
  parameter int IMPL_BITS = mmb_pkg::IMPL_W
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // program flow control
  input wire logic fetch_en_i,
  input wire logic irq_take_i,
  input wire logic jump_i,
  input wire logic [mmb_pkg::PC_W-1:0] jump_addr_i,
  // core register state
  input wire logic [7:0] core_flags_i,
  input wire logic [7:0] indirect_pointer_register_i,
  // data request
  input wire mmb_pkg::mmb_dreq_t dreq_i,
  // program bus
  output logic [mmb_pkg::PC_W-1:0] pc_o,
  output logic [IMPL_BITS-1:0] prog_addr_o,
  output logic fetch_o,
  // data bus
  output mmb_pkg::mmb_dsel_t dsel_o,
  output logic bank_unimpl_o
);
  import mmb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // program counter

  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [IMPL_BITS-1:0] prog_addr;
  logic [IMPL_BITS-1:0] next_prog_addr;
  logic fetch;
  logic next_fetch;

  always_comb begin
    next_pc = pc;
    next_fetch = 1'b0;
    if (sys_rst_i) begin
      next_pc = RESET_VEC;
    end else if (irq_take_i) begin
      next_pc = IRQ_VEC;
      next_fetch = 1'b1;
    end else if (jump_i) begin
      next_pc = jump_addr_i;
      next_fetch = 1'b1;
    end else if (fetch_en_i) begin
      next_pc = pc + 13'h0001;
      next_fetch = 1'b1;
    end
    // upper bits dropped, so fetches above 4K alias low words
    next_prog_addr = next_pc[IMPL_BITS-1:0];
  end

  always_ff @(posedge ref_clk_i) begin
    pc <= next_pc;
    prog_addr <= next_prog_addr;
    fetch <= next_fetch;
  end

  assign pc_o = pc;
  assign prog_addr_o = prog_addr;
  assign fetch_o = fetch;

  ////////////////////////////////////////////////////////////////////////////
  // data address path, independent of fetch

  logic [BANK_W-1:0] bank_sel;
  logic [FULL_W-1:0] full_addr;
  mmb_region_t region;
  logic mirrored;
  mmb_dsel_t dsel;
  mmb_dsel_t next_dsel;
  logic unimpl;
  logic next_unimpl;

  always_comb begin
    bank_sel = {core_flags_i[BSEL_HI_POS], core_flags_i[BSEL_LO_POS]};
    if (dreq_i.indirect) begin
      // pointer carries its own bank bit in bit 7, upper select above it
      full_addr = {core_flags_i[BSEL_HI_POS], indirect_pointer_register_i};
    end else begin
      full_addr = {bank_sel, dreq_i.addr};
    end
  end

  mmb_bank_decode u_dec (
    .full_addr_i(full_addr),
    .region_o(region),
    .mirrored_o(mirrored)
  );

  always_comb begin
    next_dsel = '0;
    next_dsel.region = MMB_REG_NONE;
    next_unimpl = 1'b0;
    if (!sys_rst_i && dreq_i.valid) begin
      next_dsel.valid = 1'b1;
      next_dsel.we = dreq_i.we;
      next_dsel.wdata = dreq_i.wdata;
      next_dsel.bank = full_addr[FULL_W-1:DADDR_W];
      next_dsel.region = region;
      next_dsel.mirrored = mirrored;
      // mirrored registers always land on their bank 0 copy
      next_dsel.addr = mirrored ? {BANK0, full_addr[DADDR_W-1:0]} : full_addr;
      next_unimpl = (region == MMB_REG_NONE);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    dsel <= next_dsel;
    unimpl <= next_unimpl;
  end

  assign dsel_o = dsel;
  assign bank_unimpl_o = unimpl;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence irq_seen_s;
    !sys_rst_i && irq_take_i;
  endsequence

  sequence at_vector_s;
    pc_o == IRQ_VEC && fetch_o;
  endsequence

  reset_vector_a: assert property (@(posedge ref_clk_i) sys_rst_i |=> pc_o == RESET_VEC && !fetch_o)
    else $error("pc not at reset vector after reset");

  irq_vector_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) irq_seen_s |=> at_vector_s)
    else $error("interrupt did not redirect fetch");

  pc_wrap_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    prog_addr_o == pc_o[IMPL_BITS-1:0])
    else $error("program address does not wrap pc");

  pc_step_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    fetch_en_i && !irq_take_i && !jump_i |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("pc did not advance by one");

  direct_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    dreq_i.valid && !dreq_i.indirect && region != MMB_REG_NONE && !mirrored
    |=> dsel_o.addr == {$past(core_flags_i[BSEL_HI_POS:BSEL_LO_POS]), $past(dreq_i.addr)})
    else $error("direct address not formed from bank bits");

  indirect_addr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    dreq_i.valid && dreq_i.indirect && !mirrored && region != MMB_REG_NONE
    |=> dsel_o.addr[DADDR_W:0] == $past(indirect_pointer_register_i))
    else $error("indirect address not from pointer");

  bank_unimpl_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    dreq_i.valid && !dreq_i.indirect && core_flags_i[BSEL_HI_POS] |=> bank_unimpl_o)
    else $error("upper bank not flagged unimplemented");

  region_split_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    dsel_o.valid && !bank_unimpl_o |-> (dsel_o.region == MMB_REG_SFR) == (dsel_o.addr[DADDR_W-1:0] <= SFR_LAST))
    else $error("region split wrong");

  mirror_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    dsel_o.valid && dsel_o.mirrored |-> dsel_o.addr[FULL_W-1:DADDR_W] == BANK0)
    else $error("mirrored register not folded to bank 0");

  concurrent_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    fetch_en_i && !irq_take_i && !jump_i && dreq_i.valid |=> fetch_o && dsel_o.valid)
    else $error("fetch and data not concurrent");
endmodule
`default_nettype wire

// [verification/memory_map_bank_decoder_test.sv]
// Purpose: self-checking bench for mmb_memory_map program and data paths
// Assumes: fixed one-cycle answer; inputs change on the falling edge
// Notes: data rows run with fetch enabled to show both buses in one cycle
`timescale 1ns/10ps
`default_nettype none
module memory_map_bank_decoder_test;
  import mmb_pkg::*;
  typedef struct packed {
    logic [7:0] fl;
    logic ind;
    logic [6:0] a;
    logic [7:0] p;
    logic [8:0] ea;
    mmb_region_t er;
    logic em;
    logic eu;
  } mmb_row_t;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic fetch_en_i = 1'b0;
  logic irq_take_i = 1'b0;
  logic jump_i = 1'b0;
  logic [PC_W-1:0] jump_addr_i = 13'h0000;
  logic [7:0] core_flags_i = 8'h00;
  logic [7:0] indirect_pointer_register_i = 8'h00;
  mmb_dreq_t dreq_i = '0;
  logic [PC_W-1:0] pc_o;
  logic [IMPL_W-1:0] prog_addr_o;
  logic fetch_o;
  mmb_dsel_t dsel_o;
  logic bank_unimpl_o;
  int error_cnt = 0;
  int n_checks = 0;
  logic [PC_W-1:0] epc;
  // mirrored rows sit in bank 1 only; bank 0 mirror flagging is left open
  mmb_row_t rows [12] = '{
    '{8'h00, 1'b0, 7'h05, 8'h00, 9'h005, MMB_REG_SFR, 1'b0, 1'b0},
    '{8'h00, 1'b0, 7'h1F, 8'h00, 9'h01F, MMB_REG_SFR, 1'b0, 1'b0},
    '{8'h00, 1'b0, 7'h20, 8'h00, 9'h020, MMB_REG_GPR, 1'b0, 1'b0},
    '{8'h00, 1'b0, 7'h7F, 8'h00, 9'h07F, MMB_REG_GPR, 1'b0, 1'b0},
    '{8'h9F, 1'b0, 7'h20, 8'h00, 9'h020, MMB_REG_GPR, 1'b0, 1'b0},
    '{8'h20, 1'b0, 7'h20, 8'h00, 9'h0A0, MMB_REG_GPR, 1'b0, 1'b0},
    '{8'h20, 1'b0, 7'h1F, 8'h00, 9'h09F, MMB_REG_SFR, 1'b0, 1'b0},
    '{8'h20, 1'b0, 7'h03, 8'h00, 9'h003, MMB_REG_SFR, 1'b1, 1'b0},
    '{8'h20, 1'b0, 7'h0B, 8'h00, 9'h00B, MMB_REG_SFR, 1'b1, 1'b0},
    '{8'h00, 1'b1, 7'h00, 8'hA5, 9'h0A5, MMB_REG_GPR, 1'b0, 1'b0},
    '{8'h40, 1'b1, 7'h00, 8'h30, 9'h130, MMB_REG_NONE, 1'b0, 1'b1},
    '{8'h60, 1'b0, 7'h7F, 8'h00, 9'h1FF, MMB_REG_NONE, 1'b0, 1'b1}
  };
  mmb_memory_map i_mmb_memory_map (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .fetch_en_i(fetch_en_i),
    .irq_take_i(irq_take_i),
    .jump_i(jump_i),
    .jump_addr_i(jump_addr_i),
    .core_flags_i(core_flags_i),
    .indirect_pointer_register_i(indirect_pointer_register_i),
    .dreq_i(dreq_i),
    .pc_o(pc_o),
    .prog_addr_o(prog_addr_o),
    .fetch_o(fetch_o),
    .dsel_o(dsel_o),
    .bank_unimpl_o(bank_unimpl_o)
  );
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request launched now, answer looked at one falling edge later
  task automatic prog(input logic fe, input logic irq, input logic jmp, input logic [12:0] ja);
    fetch_en_i = fe;
    irq_take_i = irq;
    jump_i = jmp;
    jump_addr_i = ja;
    @(negedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk_i);
    chk(16'(pc_o), 16'(RESET_VEC));
    chk(16'({fetch_o, bank_unimpl_o, dsel_o.valid}), 16'h0000);
    sys_rst_i = 1'b0;
    prog(1'b1, 1'b0, 1'b0, 13'h0000);
    chk(16'({fetch_o, pc_o}), 16'h2001);
    prog(1'b1, 1'b1, 1'b1, 13'h0123);
    chk(16'({fetch_o, pc_o}), 16'h2004);
    chk(16'(prog_addr_o), 16'h0004);
    prog(1'b1, 1'b0, 1'b1, 13'h1FFF);
    chk(16'(prog_addr_o), 16'h0FFF);
    prog(1'b1, 1'b0, 1'b0, 13'h0000);
    chk(16'(pc_o), 16'h0000);
    prog(1'b0, 1'b0, 1'b1, 13'h1805);
    chk(16'(prog_addr_o), 16'h0805);
    chk(16'(pc_o), 16'h1805);
    prog(1'b0, 1'b0, 1'b0, 13'h0000);
    chk(16'(pc_o), 16'h1805);
    chk(16'(fetch_o), 16'h0000);
    epc = pc_o;
    fetch_en_i = 1'b1;
    foreach (rows[i]) begin
      core_flags_i = rows[i].fl;
      indirect_pointer_register_i = rows[i].p;
      dreq_i = '{valid: 1'b1, we: i[0], indirect: rows[i].ind, addr: rows[i].a, wdata: 8'(i)};
      epc = epc + 13'h0001;
      @(negedge ref_clk_i);
      chk(16'(pc_o), 16'(epc));
      chk(16'({dsel_o.valid, bank_unimpl_o}), {15'h0000, rows[i].eu} | 16'h0002);
      chk(16'(dsel_o.region), 16'(rows[i].er));
      chk(16'(dsel_o.bank), 16'(rows[i].ind ? {rows[i].fl[6], rows[i].p[7]} : rows[i].fl[6:5]));
      chk(16'({dsel_o.we, dsel_o.wdata}), 16'({i[0], 8'(i)}));
      if (rows[i].eu === 1'b0) begin
        chk(16'(dsel_o.addr), 16'(rows[i].ea));
        chk(16'(dsel_o.mirrored), 16'(rows[i].em));
      end
    end
    dreq_i = '0;
    @(negedge ref_clk_i);
    chk(16'({dsel_o.valid, bank_unimpl_o}), 16'h0000);
    chk(16'(dsel_o.region), 16'(MMB_REG_NONE));
    sys_rst_i = 1'b1;
    @(negedge ref_clk_i);
    chk(16'({fetch_o, pc_o}), 16'h0000);
    chk(16'(dsel_o.region), 16'(MMB_REG_NONE));
    // second release with fetch still requested: first advance starts at the reset vector
    sys_rst_i = 1'b0;
    @(negedge ref_clk_i);
    chk(16'({fetch_o, pc_o}), 16'h2001);
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
